/* hdl/slcs_core.sv */
// Control decode, interrupts, service requests and status of the serial link card.
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module slcs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic rdy;
  } slcs_fifo_type;
  slcs_fifo_type s_r, s_nxt;
  logic push, pop;
  assign in_ready = s_r.rdy;
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  always_comb
  begin
    push = in_valid && s_r.rdy;
    pop = out_valid && out_ready;
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
    end
    if (pop)
    begin
      s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + CW'(push) - CW'(pop);
    if (flush)
    begin
      s_nxt.wp = '0;
      s_nxt.rp = '0;
      s_nxt.cnt = '0;
    end
    s_nxt.rdy = (s_nxt.cnt != CW'(DEPTH));
    if (!rstn)
    begin
      s_nxt = '0;
      s_nxt.rdy = 1'b1;
    end
  end
  always_ff @(posedge core_clk)
  begin
    s_r <= s_nxt;
  end
endmodule : slcs_fifo
////////////////////////////////////////////////////////////////////////////////
module slcs_core
  import slcs_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = slcs_pkg::TIMEOUT_CYC,
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Control word and status
  input wire logic ctl_stb,
  input wire logic [slcs_pkg::CW_W-1:0] ctl_word,
  output logic [slcs_pkg::CW_W-1:0] sts_word,
  // Host data
  input wire logic wr_valid,
  input wire logic [slcs_pkg::CW_W-1:0] wr_data,
  output logic wr_ready,
  output logic rd_valid,
  output logic [slcs_pkg::CW_W-1:0] rd_data,
  input wire logic rd_ready,
  // Channel program and interrupt
  input wire logic prog_start,
  input wire logic prog_end,
  input wire logic xfer_err,
  input wire logic set_int,
  input wire logic int_reset,
  output logic int_req,
  output logic svc_req,
  output logic dev_end,
  output logic cond_jump,
  output logic clear_int,
  // Shifter and CRC unit
  input wire logic rx_valid,
  input wire logic [slcs_pkg::CW_W-1:0] rx_word,
  input wire logic rx_tag,
  input wire logic tx_ready,
  input wire logic crc_err,
  output logic tx_valid,
  output logic [slcs_pkg::CW_W-1:0] tx_word,
  output logic tx_tag,
  output logic tx_line_off,
  output logic crc_on_tx,
  output logic tx_send_crc,
  output logic crc_test,
  output logic shift_reset,
  output logic bit_tick,
  output logic rx_off,
  output logic handshake,
  output logic repeat_mode,
  // Channel pins
  input wire logic [slcs_pkg::NCH-1:0] dsr_pin,
  output logic [1:0] chan_sel,
  output logic [slcs_pkg::NCH-1:0] dtr,
  output logic [slcs_pkg::NCH-1:0] rts
);
  import slcs_pkg::*;
  typedef struct packed {
    logic [7:0] rate;
    logic [7:0] bcnt;
    logic [4:0] base;
    logic [1:0] chan;
    logic [5:0] cmp;
    logic ime, rxdis, rxie, orie;
    logic [3:0] actm, actn;
    logic [NCH-1:0] dtr, rts, s1, s2, s3, dsr;
    logic toie, srie, crcie, ack, rep;
    logic txdis, txie, crctx, sendcrc, tag, dummy;
    logic busy;
    logic [IP_N-1:0] pend;
    logic tmof, ovr, crcf, xerr, tagd, cmpd, srv;
    logic [1:0] reqch;
    logic rdv;
    logic [CW_W-1:0] rbuf;
    logic txv, txt;
    logic [CW_W-1:0] txw;
    logic wrq;
    slcs_rep_type rep_st;
    logic [1:0] repc;
    logic [CW_W-1:0] repw;
    logic [31:0] tmo;
    logic svc, dend, cjmp, clri, shrst, ctest, tick, intr;
    logic [CW_W-1:0] sts;
  } slcs_state_type;
  slcs_state_type s_r, n, keep;
  logic [2:0] fn;
  logic [IP_N-1:0] ev;
  logic [NCH-1:0] chg;
  logic [3:0] act;
  logic xfer, hit, take, sup, rxsvc, rise, load, ftake, fl, crst;
  logic fifo_rdy, fifo_v;
  logic [CW_W-1:0] fifo_d;

  slcs_fifo #(.WIDTH(CW_W), .DEPTH(FIFO_DEPTH)) u_txq (
    .core_clk(core_clk),
    .rstn(rstn),
    .flush(fl),
    .in_valid(wr_valid),
    .in_data(wr_data),
    .in_ready(fifo_rdy),
    .out_valid(fifo_v),
    .out_data(fifo_d),
    .out_ready(ftake)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n = s_r;
    keep = s_r;
    fn = ctl_word[FN_MSB:FN_LSB]; // [RULE_01]
    ev = '0;
    act = '0;
    hit = 1'b0;
    take = 1'b0;
    sup = 1'b0;
    rxsvc = 1'b0;
    ftake = 1'b0;
    {n.svc, n.dend, n.cjmp, n.clri, n.shrst, n.ctest, n.tick} = '0;
    crst = ctl_stb && (fn == FN_CARDRST);
    fl = crst || (ctl_stb && (fn == FN_SHRST)) || !rstn;
    xfer = (wr_valid && fifo_rdy) || (s_r.rdv && rd_ready);
    if (int_reset)
    begin
      n.pend = '0;
      {n.tmof, n.ovr, n.crcf, n.xerr, n.tagd, n.cmpd, n.srv} = '0;
    end
    if (ctl_stb)
    begin
      unique case (fn)
        FN_RATE:
        begin
          n.rate = {<<{ctl_word[RATE_MSB:0]}}; // [RULE_02] [RULE_03]
          n.chan = ctl_word[CH_MSB:CH_LSB]; // [RULE_04]
          n.bcnt = n.rate;
          n.base = '0;
        end
        FN_TAGCMP: n.cmp = ctl_word[TAG_MSB:TAG_LSB]; // [RULE_05]
        FN_INTMST:
        begin
          n.ime = ctl_word[B3]; // [RULE_06]
          if (!ctl_word[B3])
          begin
            n.pend = '0;
          end
        end
        FN_RXACT:
        begin
          n.rxdis = ctl_word[RXDIS_B]; // [RULE_07]
          n.rxie = ctl_word[RXIE_B];
          n.orie = ctl_word[ORIE_B];
          n.actm = ctl_word[ACTM_MSB:ACTM_LSB]; // [RULE_08]
          n.actn = ctl_word[ACTN_MSB:ACTN_LSB]; // [RULE_09]
        end
        FN_CARDRST: n.clri = 1'b1;
        FN_SHRST:
        begin
          n.shrst = 1'b1; // [RULE_11]
          n.rdv = 1'b0;
          n.txv = 1'b0;
          n.dummy = 1'b0;
        end
        FN_RXMODE:
        begin
          n.dtr[s_r.chan] = ctl_word[B3]; // [RULE_12]
          n.toie = ctl_word[TOIE_B]; // [RULE_13]
          n.srie = ctl_word[SRIE_B];
          n.crcie = ctl_word[CRCIE_B];
          n.ack = ctl_word[ACK_B]; // [RULE_14]
          n.rep = ctl_word[REP_B];
        end
        FN_TXMODE:
        begin
          n.rts[s_r.chan] = ctl_word[B3]; // [RULE_12]
          n.txdis = ctl_word[TXDIS_B]; // [RULE_15]
          n.txie = ctl_word[TXIE_B]; // [RULE_16]
          n.crctx = ctl_word[CRCTX_B]; // [RULE_17]
          n.sendcrc = ctl_word[SENDCRC_B];
          n.tag = ctl_word[TAGOUT_B]; // [RULE_19]
          n.ctest = ctl_word[TEST_B]; // [RULE_18]
          n.dummy = ctl_word[TEST_B];
        end
      endcase
    end
    // Bit rate: a 2.5 MHz base enable steps a counter preset from the rate code.
    if (ctl_stb && (fn == FN_RATE))
    begin
      n.base = '0;
    end
    else if (s_r.base == 5'(BASE_DIV - 1))
    begin
      n.base = '0;
      if (s_r.bcnt == 8'hFF)
      begin
        n.bcnt = s_r.rate; // [RULE_02]
        n.tick = 1'b1;
      end
      else
      begin
        n.bcnt = s_r.bcnt + 8'h01;
      end
    end
    else
    begin
      n.base = s_r.base + 5'h01;
    end
    // Data set ready pins pass three flops and count once two agree.
    n.s1 = dsr_pin;
    n.s2 = s_r.s1;
    n.s3 = s_r.s2;
    if (s_r.s2 == s_r.s3)
    begin
      n.dsr = s_r.s3;
    end
    chg = n.dsr ^ s_r.dsr;
    if (chg != '0)
    begin
      n.srv = 1'b1; // [RULE_21] [RULE_23]
      ev[IP_SR] = s_r.srie; // [RULE_13]
      for (int i = NCH - 1; i >= 0; i--)
      begin
        if (chg[i])
        begin
          n.reqch = 2'(i);
        end
      end
    end
    // Receive buffer.
    if (s_r.rdv && rd_ready)
    begin
      n.rdv = 1'b0;
    end
    if (rx_valid && !s_r.rxdis) // [RULE_07]
    begin
      if (rx_tag)
      begin
        hit = (rx_word[TAG_MSB:TAG_LSB] == s_r.cmp) || rx_word[BCAST_BIT]; // [RULE_05]
        act = hit ? s_r.actm : s_r.actn; // [RULE_08] [RULE_09]
        n.tagd = 1'b1; // [RULE_24]
        n.cmpd = s_r.cmpd || hit;
        n.dend = act[ACT_DE];
        n.cjmp = act[ACT_CJ];
        ev[IP_TAG] = act[ACT_INT];
        sup = act[ACT_DSR];
        take = 1'b1;
        if (s_r.rep && hit && (s_r.rep_st == REP_IDLE)) // [RULE_14]
        begin
          n.rep_st = REP_WAIT;
          n.repw = rx_word;
          n.repc = '0;
        end
      end
      else
      begin
        take = !s_r.rep; // [RULE_14]
      end
      if (take)
      begin
        if (n.rdv)
        begin
          n.ovr = 1'b1; // [RULE_24]
          ev[IP_OVR] = s_r.orie; // [RULE_07]
        end
        n.rdv = 1'b1;
        n.rbuf = rx_word;
        ev[IP_RX] = s_r.rxie;
        rxsvc = !sup;
      end
    end
    // Repeat echo, two bit times after the tag word.
    unique case (s_r.rep_st)
      REP_IDLE: ;
      REP_WAIT:
      begin
        if (s_r.tick)
        begin
          n.repc = s_r.repc + 2'h1;
          if (s_r.repc == 2'(REP_BITS - 1))
          begin
            n.rep_st = REP_SEND;
          end
        end
      end
      REP_SEND: ;
      default: n.rep_st = REP_IDLE;
    endcase
    // Transmit stage fed from the queue, the echo or a dummy word.
    load = !s_r.txv || tx_ready;
    if (s_r.txv && tx_ready)
    begin
      n.txv = 1'b0;
    end
    if (load)
    begin
      if (s_r.rep_st == REP_SEND)
      begin
        n.txv = 1'b1;
        n.txw = s_r.repw;
        n.txt = 1'b1;
        n.rep_st = REP_IDLE;
      end
      else if (s_r.dummy)
      begin
        n.txv = 1'b1; // [RULE_18]
        n.txw = '0;
        n.txt = s_r.tag;
        n.dummy = 1'b0;
      end
      else if (fifo_v)
      begin
        ftake = 1'b1;
        n.txv = 1'b1;
        n.txw = fifo_d;
        n.txt = s_r.tag; // [RULE_19]
      end
    end
    n.wrq = fifo_rdy;
    rise = fifo_rdy && !s_r.wrq;
    ev[IP_TX] = rise && s_r.txie; // [RULE_16]
    // Time-out: every host data transfer restarts it.
    if (xfer)
    begin
      n.tmo = '0;
    end
    else if (s_r.tmo != 32'(TIMEOUT_CYCLES))
    begin
      n.tmo = s_r.tmo + 32'h1;
      if (s_r.tmo == 32'(TIMEOUT_CYCLES - 1))
      begin
        n.tmof = 1'b1; // [RULE_13]
        ev[IP_TMO] = s_r.toie;
      end
    end
    if (crc_err)
    begin
      n.crcf = 1'b1; // [RULE_24]
      ev[IP_CRC] = s_r.crcie;
    end
    if (xfer_err)
    begin
      n.xerr = 1'b1; // [RULE_21]
      ev[IP_XERR] = 1'b1;
    end
    ev[IP_SET] = set_int;
    if (prog_start)
    begin
      n.busy = 1'b1;
    end
    if (prog_end)
    begin
      n.busy = 1'b0;
    end
    n.svc = s_r.busy && (ctl_stb || rxsvc || rise || prog_end); // [RULE_20]
    n.pend = n.pend | ev; // [RULE_21]
    n.intr = n.ime && (n.pend != '0); // [RULE_06]
    n.sts = '0;
    n.sts[ST_IDLE] = !n.busy; // [RULE_22]
    n.sts[ST_RBUF] = n.rdv;
    n.sts[ST_WBUF] = fifo_rdy;
    n.sts[ST_RW] = n.rdv || fifo_rdy;
    n.sts[ST_PEND] = (n.pend != '0);
    n.sts[ST_XERR] = n.xerr; // [RULE_23]
    n.sts[ST_TMO] = n.tmof;
    n.sts[ST_SRV] = n.srv;
    n.sts[ST_SRC] = 1'b0;
    n.sts[ST_CH_MSB:ST_CH_LSB] = n.reqch;
    n.sts[ST_SENSE] = (n.dsr != '0);
    n.sts[ST_CRC] = n.crcf; // [RULE_24]
    n.sts[ST_OVR] = n.ovr;
    n.sts[ST_TAGD] = n.tagd;
    n.sts[ST_CMP] = n.cmpd;
    if (!rstn || crst)
    begin
      keep = n;
      n = '0;
      n.rep_st = REP_IDLE;
      n.sts[ST_IDLE] = 1'b1;
      n.sts[ST_WBUF] = 1'b1;
      n.sts[ST_RW] = 1'b1;
      if (rstn)
      begin
        n.s1 = keep.s1;
        n.s2 = keep.s2;
        n.s3 = keep.s3;
        n.dsr = keep.dsr;
        n.clri = 1'b1; // [RULE_10]
        n.shrst = 1'b1;
        if (ctl_word[B3])
        begin
          n.dtr = keep.dtr;
          n.rts = keep.rts;
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    s_r <= n;
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign sts_word = s_r.sts;
  assign wr_ready = fifo_rdy;
  assign rd_valid = s_r.rdv;
  assign rd_data = s_r.rbuf;
  assign int_req = s_r.intr;
  assign svc_req = s_r.svc;
  assign dev_end = s_r.dend;
  assign cond_jump = s_r.cjmp;
  assign clear_int = s_r.clri;
  assign tx_valid = s_r.txv;
  assign tx_word = s_r.txw;
  assign tx_tag = s_r.txt;
  assign tx_line_off = s_r.txdis;
  assign crc_on_tx = s_r.crctx;
  assign tx_send_crc = s_r.sendcrc;
  assign crc_test = s_r.ctest;
  assign shift_reset = s_r.shrst;
  assign bit_tick = s_r.tick;
  assign rx_off = s_r.rxdis;
  assign handshake = s_r.ack;
  assign repeat_mode = s_r.rep;
  assign chan_sel = s_r.chan;
  assign dtr = s_r.dtr;
  assign rts = s_r.rts;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  chan_load_a: assert property (ctl_stb && fn == FN_RATE |=> // [RULE_04]
    chan_sel == $past(ctl_word[CH_MSB:CH_LSB])) else $error("channel not loaded");
  tick_gap_a: assert property (bit_tick |=> !bit_tick [*8]) // [RULE_02]
    else $error("bit ticks too close");
  int_off_a: assert property (ctl_stb && fn == FN_INTMST && !ctl_word[B3] // [RULE_06]
    |=> !int_req ##1 !int_req) else $error("interrupt not disabled");
  ovr_flag_a: assert property (rx_valid && !rx_off && !rx_tag && !repeat_mode && // [RULE_07]
    rd_valid && !rd_ready && !ctl_stb |=> sts_word[ST_OVR]) else $error("overrun missed");
  dtr_drive_a: assert property (ctl_stb && fn == FN_RXMODE |=> // [RULE_12]
    dtr[$past(chan_sel)] == $past(ctl_word[B3])) else $error("dtr not driven");
  line_off_a: assert property (ctl_stb && fn == FN_TXMODE |=> // [RULE_15]
    tx_line_off == $past(ctl_word[TXDIS_B])) else $error("line disable wrong");
  card_rst_a: assert property (crst |=> clear_int && !int_req && // [RULE_10]
    shift_reset) else $error("card reset incomplete");
  svc_order_a: assert property (ctl_stb && !sts_word[ST_IDLE] && !crst // [RULE_20]
    |=> svc_req) else $error("service request missing");
  rw_or_a: assert property (sts_word[ST_RW] == // [RULE_22]
    (sts_word[ST_RBUF] || sts_word[ST_WBUF])) else $error("status bit one wrong");
endmodule : slcs_core

/* hdl/slcs_pkg.sv */
// Constants and field layout for the serial link control and status block.
// Notes on behaviour
// RULE_01: Top three control word bits select function.
// RULE_02: Function zero low byte sets bit rate.
// RULE_03: Host writes rate as reversed two's complement.
// RULE_04: Function zero two-bit field selects channel.
// RULE_05: Function one loads six-bit tag compare pattern.
// RULE_06: Function two enables or clears all interrupts.
// RULE_07: Function three: receive disable, word, overrun interrupts.
// RULE_08: Matching tag words use action bits 8-11.
// RULE_09: Other tag words use action bits 12-15.
// RULE_10: Function four resets card; bit three keeps handshakes.
// RULE_11: Function five resets shift and CRC registers.
// RULE_12: Functions six, seven bit three drive DTR, RTS.
// RULE_13: Function six enables timeout, remote, CRC interrupts.
// RULE_14: Function six selects handshake and repeat modes.
// RULE_15: Transmit disable holds the line at zero.
// RULE_16: Transmit interrupt on write-ready leading edge.
// RULE_17: Choose CRC accumulation side; send CRC instead.
// RULE_18: Test CRC sends one dummy word first.
// RULE_19: Tag bit goes out with transmitted word.
// RULE_20: Service request on four channel program events.
// RULE_21: Interrupt and status for each event kind.
// RULE_22: Status bits zero to four: idle, ready, pending.
// RULE_23: Status bits five to eleven: events and channel.
// RULE_24: Status bits twelve to fifteen: CRC, overrun, tag.
package slcs_pkg;
  localparam int CW_W = 16;
  localparam int CW_TOP = CW_W - 1;
  localparam int FN_MSB = CW_TOP;
  localparam int FN_LSB = CW_TOP - 2;
  localparam logic [2:0] FN_RATE = 3'h0;
  localparam logic [2:0] FN_TAGCMP = 3'h1;
  localparam logic [2:0] FN_INTMST = 3'h2;
  localparam logic [2:0] FN_RXACT = 3'h3;
  localparam logic [2:0] FN_CARDRST = 3'h4;
  localparam logic [2:0] FN_SHRST = 3'h5;
  localparam logic [2:0] FN_RXMODE = 3'h6;
  localparam logic [2:0] FN_TXMODE = 3'h7;
  localparam int B3 = CW_TOP - 3;
  localparam int CH_MSB = CW_TOP - 6;
  localparam int CH_LSB = CW_TOP - 7;
  localparam int RATE_MSB = CW_TOP - 8;
  localparam int TAG_MSB = CW_TOP - 9;
  localparam int TAG_LSB = CW_TOP - 14;
  localparam int BCAST_BIT = CW_TOP - 15;
  localparam int RXDIS_B = CW_TOP - 5;
  localparam int RXIE_B = CW_TOP - 6;
  localparam int ORIE_B = CW_TOP - 7;
  localparam int ACTM_MSB = CW_TOP - 8;
  localparam int ACTM_LSB = CW_TOP - 11;
  localparam int ACTN_MSB = CW_TOP - 12;
  localparam int ACTN_LSB = CW_TOP - 15;
  localparam int ACT_DSR = 3;
  localparam int ACT_DE = 2;
  localparam int ACT_CJ = 1;
  localparam int ACT_INT = 0;
  localparam int TOIE_B = CW_TOP - 10;
  localparam int SRIE_B = CW_TOP - 11;
  localparam int CRCIE_B = CW_TOP - 12;
  localparam int ACK_B = CW_TOP - 13;
  localparam int REP_B = CW_TOP - 14;
  localparam int TXDIS_B = CW_TOP - 10;
  localparam int TXIE_B = CW_TOP - 11;
  localparam int CRCTX_B = CW_TOP - 12;
  localparam int TEST_B = CW_TOP - 13;
  localparam int SENDCRC_B = CW_TOP - 14;
  localparam int TAGOUT_B = CW_TOP - 15;
  localparam int ST_IDLE = CW_TOP - 0;
  localparam int ST_RW = CW_TOP - 1;
  localparam int ST_PEND = CW_TOP - 2;
  localparam int ST_RBUF = CW_TOP - 3;
  localparam int ST_WBUF = CW_TOP - 4;
  localparam int ST_XERR = CW_TOP - 5;
  localparam int ST_TMO = CW_TOP - 6;
  localparam int ST_SRV = CW_TOP - 7;
  localparam int ST_SRC = CW_TOP - 8;
  localparam int ST_CH_MSB = CW_TOP - 9;
  localparam int ST_CH_LSB = CW_TOP - 10;
  localparam int ST_SENSE = CW_TOP - 11;
  localparam int ST_CRC = CW_TOP - 12;
  localparam int ST_OVR = CW_TOP - 13;
  localparam int ST_TAGD = CW_TOP - 14;
  localparam int ST_CMP = CW_TOP - 15;
  localparam int IP_XERR = 0;
  localparam int IP_SET = 1;
  localparam int IP_RX = 2;
  localparam int IP_TX = 3;
  localparam int IP_OVR = 4;
  localparam int IP_TMO = 5;
  localparam int IP_SR = 6;
  localparam int IP_CRC = 7;
  localparam int IP_TAG = 8;
  localparam int IP_N = 9;
  localparam int NCH = 4;
  localparam longint CLK_HZ = 50000000;
  localparam longint BASE_HZ = 2500000;
  localparam int BASE_DIV = int'(CLK_HZ / BASE_HZ);
  localparam longint TIMEOUT_MS = 15;
  localparam int TIMEOUT_CYC = int'(CLK_HZ * TIMEOUT_MS / 1000);
  localparam int REP_BITS = 2;
  typedef enum logic [2:0] {
    REP_IDLE = 3'h1,
    REP_WAIT = 3'h2,
    REP_SEND = 3'h4
  } slcs_rep_type;
endpackage : slcs_pkg

/* verif/slcs_link_model.sv */
// Far-side model: transmit shifter that can stall, and a cable that loops terminal ready back.
`timescale 1ns/10ps
module slcs_link_model (
  // Clock and bench control
  input wire logic core_clk,
  input wire logic stall,
  // Transmit path
  input wire logic tx_valid,
  input wire logic [15:0] tx_word,
  input wire logic tx_tag,
  output logic tx_ready,
  // Channel handshakes
  input wire logic [3:0] dtr,
  output logic [3:0] dsr_pin
);
  logic [16:0] got[$];
  assign tx_ready = !stall;
  assign dsr_pin = dtr;
  always @(posedge core_clk)
  begin
    if (tx_valid && tx_ready)
    begin
      got.push_back({tx_tag, tx_word});
    end
  end
endmodule : slcs_link_model

/* verif/slcs_core_tb.sv */
// Self-checking testbench of the serial link control and status block.
`timescale 1ns/10ps
module slcs_core_tb;
  import slcs_pkg::*;
  logic core_clk = 0, rstn = 0, ctl_stb = 0, wr_valid = 0, rd_ready = 0, prog_start = 0;
  logic prog_end = 0, xfer_err = 0, set_int = 0, int_reset = 0, rx_valid = 0, rx_tag = 0;
  logic crc_err = 0, stall = 0, wr_ready, rd_valid, int_req, svc_req, dev_end, cond_jump;
  logic clear_int, tx_ready, tx_valid, tx_tag, tx_line_off, crc_on_tx, tx_send_crc;
  logic crc_test, shift_reset, bit_tick, rx_off, handshake, repeat_mode;
  logic [15:0] ctl_word = 0, wr_data = 0, rx_word = 0, sts_word, rd_data, tx_word;
  logic [3:0] dsr_pin, dtr, rts;
  logic [1:0] chan_sel;
  logic [5:0] seen = 0;
  int n_fail = 0, checked = 0, n, t;
  slcs_core #(.TIMEOUT_CYCLES(50)) dut_u (.core_clk, .rstn, .ctl_stb, .ctl_word, .sts_word,
    .wr_valid, .wr_data, .wr_ready, .rd_valid, .rd_data, .rd_ready, .prog_start, .prog_end,
    .xfer_err, .set_int, .int_reset, .int_req, .svc_req, .dev_end, .cond_jump, .clear_int,
    .rx_valid, .rx_word, .rx_tag, .tx_ready, .crc_err, .tx_valid, .tx_word, .tx_tag,
    .tx_line_off, .crc_on_tx, .tx_send_crc, .crc_test, .shift_reset, .bit_tick, .rx_off,
    .handshake, .repeat_mode, .dsr_pin, .chan_sel, .dtr, .rts);
  slcs_link_model p_u (.core_clk, .stall, .tx_valid, .tx_word, .tx_tag, .tx_ready, .dtr,
    .dsr_pin);
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #10 core_clk = ~core_clk;
  end
  // Pulse outputs are collected here so their exact cycle does not matter.
  always @(posedge core_clk)
  begin
    seen <= seen | {clear_int, shift_reset, crc_test, svc_req, dev_end, cond_jump};
  end
  initial
  begin
    #1000000;
    n_fail++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] enc(input int d);
    logic [7:0] c;
    c = 8'(-d);
    return {<<{c}};
  endfunction : enc
  task ck(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : ck
  task ck1(input logic g, input logic e);
    ck({15'h0, g}, {15'h0, e});
  endtask : ck1
  task cy(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : cy
  task cw(input logic [15:0] w);
    seen = 0;
    ctl_word = w;
    ctl_stb = 1;
    cy(1);
    ctl_stb = 0;
    cy(2);
  endtask : cw
  task automatic pl(ref logic s);
    seen = 0;
    s = 1;
    cy(1);
    s = 0;
    cy(2);
  endtask : pl
  task rx(input logic [15:0] w, input logic g);
    seen = 0;
    rx_word = w;
    rx_tag = g;
    rx_valid = 1;
    cy(1);
    rx_valid = 0;
    cy(2);
  endtask : rx
  task results;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    cy(3);
    rstn = 1;
    ck(sts_word, 16'hC800);
    ck1(wr_ready, 1'h1);
    $display("reset test done");
    cw({6'h00, 2'h1, enc(250)});
    ck({14'h0, chan_sel}, 16'h1);
    t = 0;
    while (!bit_tick && t < 6000)
    begin
      cy(1);
      t++;
    end
    n = 1;
    cy(1);
    while (!bit_tick && n < 6000)
    begin
      cy(1);
      n++;
    end
    ck(16'(n), 16'(250 * BASE_DIV));
    $display("rate test done");
    cw(16'hD024);
    ck({12'h0, dtr}, 16'h2);
    ck1(handshake, 1'h1);
    pl(wr_valid);
    cy(60);
    ck(sts_word & 16'h01E0, 16'h0120);
    ck(sts_word & 16'h2200, 16'h2200);
    ck1(int_req, 1'h0);
    cw(16'h5000);
    ck1(int_req, 1'h1);
    cw(16'h4000);
    ck1(int_req, 1'h0);
    $display("mode and interrupt test done");
    cw(16'hF02F);
    ck({9'h0, rts, tx_line_off, crc_on_tx, tx_send_crc}, 16'h17);
    ck1(seen[3], 1'h1);
    cw(16'h9000);
    ck({8'h0, dtr, rts}, 16'h22);
    ck1(seen[5] & seen[4], 1'h1);
    cw(16'h8000);
    ck({8'h0, dtr, rts}, 16'h0);
    cw(16'hA000);
    ck1(seen[4], 1'h1);
    $display("reset functions test done");
    pl(prog_start);
    ck1(sts_word[15], 1'h0);
    cw(16'h2054);
    ck1(seen[2], 1'h1);
    cw(16'h6042);
    rx(16'h0054, 1'h1);
    ck({seen[1:0], 12'h0, sts_word[1:0]}, 16'h8003);
    rx(16'h0002, 1'h1);
    ck1(seen[0], 1'h1);
    rx(16'h1234, 1'h0);
    ck(rd_data, 16'h1234);
    ck1(sts_word[12] & sts_word[14] & rd_valid, 1'h1);
    rx(16'h5678, 1'h0);
    ck1(sts_word[2], 1'h1);
    pl(rd_ready);
    pl(rd_ready);
    ck1(rd_valid, 1'h0);
    cw(16'h6400);
    ck1(rx_off, 1'h1);
    rx(16'h1111, 1'h0);
    ck1(rd_valid, 1'h0);
    cw(16'h6000);
    pl(xfer_err);
    ck1(sts_word[10], 1'h1);
    pl(prog_end);
    ck1(sts_word[15], 1'h1);
    pl(int_reset);
    ck1(sts_word[10], 1'h0);
    cw(16'h5000);
    pl(set_int);
    ck1(int_req, 1'h1);
    pl(crc_err);
    ck1(sts_word[3], 1'h1);
    $display("receive and program test done");
    cw(16'hE001);
    stall = 1;
    p_u.got.delete();
    n = 0;
    while (wr_ready === 1'h1 && n < 12)
    begin
      wr_data = 16'hA000 | 16'(n);
      wr_valid = 1;
      cy(1);
      n++;
    end
    wr_valid = 0;
    ck1(n >= 8, 1'h1);
    cy(1);
    ck1(sts_word[11], 1'h0);
    stall = 0;
    cy(40);
    ck(16'(p_u.got.size()), 16'(n));
    for (t = 0; t < n; t++)
    begin
      ck(p_u.got[t][15:0], 16'hA000 | 16'(t));
      ck1(p_u.got[t][16], 1'h1);
    end
    ck1(wr_ready & sts_word[11], 1'h1);
    $display("transmit buffer test done");
    cw({6'h00, 2'h0, enc(1)});
    cw(16'hC002);
    ck1(repeat_mode, 1'h1);
    p_u.got.delete();
    rx(16'h0054, 1'h1);
    rx(16'h5555, 1'h0);
    ck(rd_data, 16'h0054);
    cy(60);
    ck(16'(p_u.got.size()), 16'h1);
    ck(p_u.got[0][15:0], 16'h0054);
    ck1(p_u.got[0][16], 1'h1);
    $display("repeat test done");
    results();
  end
endmodule : slcs_core_tb
